//--- hw/ascm_master.sv
`timescale 1ns/1ps
module ascm_master
    import ascm_pkg::*;
(
    // System clock and control
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic start_cfg,
    input wire logic compressed_in,
    input wire logic jtag_cfg_in,
    // Link clock, chosen by the clock selection outside
    input wire logic link_clk,
    input wire logic link_reset_n,
    // Pins toward memory
    output logic cfg_mem_select_n_out,
    output logic cfg_mem_select_oe_n,
    output logic cfg_serial_clock_out,
    output logic cfg_serial_clock_oe_n,
    output logic serial_cmd_address_out,
    output logic serial_cmd_address_oe_n,
    input wire logic cfg_data_in,
    // Byte output and status
    output logic [7:0] cfg_byte,
    output logic cfg_byte_valid,
    input wire logic cfg_byte_ready,
    output logic cfg_busy,
    output logic cfg_done,
    output logic cfg_aborted
);
    ascm_state_type st_reg, st_next;
    logic [5:0] hcnt_reg, hcnt_next;
    logic [31:0] hsh_reg, hsh_next;
    logic [2:0] bcnt_reg, bcnt_next;
    logic [7:0] rsh_reg, rsh_next;
    logic [23:0] left_reg, left_next;
    logic sclk_reg, sclk_next;
    logic sel_reg, sel_next;
    logic oe_n_reg, oe_n_next;
    logic push_tgl_reg, push_tgl_next;
    logic [7:0] xfer_reg, xfer_next;
    logic comp_reg, comp_next;
    logic din_s1_reg, din_s2_reg;
    logic start_s1_reg, start_s2_reg, jtag_s1_reg, jtag_s2_reg, comp_s1_reg, comp_s2_reg;
    logic ack_s1_reg, ack_s2_reg;
    logic ack_tgl_reg, ack_tgl_next;
    logic stall;

    // Link side inputs pass two flops before use
    always_ff @(posedge link_clk or negedge link_reset_n)
    begin
        if (!link_reset_n)
        begin
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
            start_s1_reg <= 1'b0;
            start_s2_reg <= 1'b0;
            jtag_s1_reg <= 1'b0;
            jtag_s2_reg <= 1'b0;
            comp_s1_reg <= 1'b0;
            comp_s2_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end
        else
        begin
            din_s1_reg <= cfg_data_in;
            din_s2_reg <= din_s1_reg;
            start_s1_reg <= start_cfg;
            start_s2_reg <= start_s1_reg;
            jtag_s1_reg <= jtag_cfg_in;
            jtag_s2_reg <= jtag_s1_reg;
            comp_s1_reg <= compressed_in;
            comp_s2_reg <= comp_s1_reg;
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // Pending byte handshake: stall the link until the system side took it
    assign stall = (push_tgl_reg != ack_s2_reg);

    // Link state machine; serial clock is link clock halved, so a link clock
    // of at most 40 MHz from oscillator or user clock keeps it in range
    always_comb
    begin
        st_next = st_reg;
        hcnt_next = hcnt_reg;
        hsh_next = hsh_reg;
        bcnt_next = bcnt_reg;
        rsh_next = rsh_reg;
        left_next = left_reg;
        sclk_next = sclk_reg;
        sel_next = sel_reg;
        oe_n_next = oe_n_reg;
        push_tgl_next = push_tgl_reg;
        xfer_next = xfer_reg;
        comp_next = comp_reg;
        case (st_reg)
            ASCM_IDLE:
            begin
                if (start_s2_reg && !jtag_s2_reg)
                begin
                    sel_next = 1'b0;
                    oe_n_next = 1'b0;
                    hsh_next = {ASCM_READ_CMD, ASCM_START_ADDR};
                    hcnt_next = '0;
                    comp_next = comp_s2_reg;
                    st_next = ASCM_HEADER;
                end
            end
            ASCM_HEADER:
            begin
                sclk_next = ~sclk_reg;
                if (sclk_reg)
                begin
                    // Shift on falling edge so memory samples on rising
                    hsh_next = {hsh_reg[30:0], 1'b0};
                    if (hcnt_reg == ASCM_HDR_LAST)
                    begin
                        st_next = ASCM_STREAM;
                        bcnt_next = '0;
                        left_next = ASCM_STREAM_BYTES;
                    end
                    hcnt_next = hcnt_reg + 6'h01;
                end
            end
            ASCM_STREAM:
            begin
                // Clock held high while a byte waits: the next bit is not launched yet
                if (!stall || !sclk_reg)
                    sclk_next = ~sclk_reg;
                // First rising edge only fills the synchroniser with the first bit
                if (!sclk_reg)
                    hcnt_next = {hcnt_reg[5:1], 1'b1};
                if (!sclk_reg && !stall && hcnt_reg[0])
                begin
                    rsh_next = {rsh_reg[6:0], din_s2_reg};
                    bcnt_next = bcnt_reg + 3'h1;
                    if (bcnt_reg == 3'h7)
                    begin
                        xfer_next = {rsh_reg[6:0], din_s2_reg};
                        push_tgl_next = ~push_tgl_reg;
                        left_next = left_reg - 24'h000001;
                        if (left_reg == 24'h000001)
                            st_next = ASCM_DONE;
                    end
                end
            end
            ASCM_DONE:
            begin
                sclk_next = 1'b0;
                sel_next = 1'b1;
                oe_n_next = 1'b1;
            end
            default:
            begin
                sclk_next = 1'b0;
                sel_next = 1'b1;
                oe_n_next = 1'b1;
                st_next = ASCM_ABORT;
            end
        endcase
        // Test port loading takes priority
        if (jtag_s2_reg && st_reg != ASCM_IDLE && st_reg != ASCM_DONE)
        begin
            st_next = ASCM_ABORT;
            sclk_next = 1'b0;
            sel_next = 1'b1;
            oe_n_next = 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge link_reset_n)
    begin
        if (!link_reset_n)
        begin
            st_reg <= ASCM_IDLE;
            hcnt_reg <= '0;
            hsh_reg <= '0;
            bcnt_reg <= '0;
            rsh_reg <= '0;
            left_reg <= '0;
            sclk_reg <= 1'b0;
            sel_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            push_tgl_reg <= 1'b0;
            xfer_reg <= '0;
            comp_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            hcnt_reg <= hcnt_next;
            hsh_reg <= hsh_next;
            bcnt_reg <= bcnt_next;
            rsh_reg <= rsh_next;
            left_reg <= left_next;
            sclk_reg <= sclk_next;
            sel_reg <= sel_next;
            oe_n_reg <= oe_n_next;
            push_tgl_reg <= push_tgl_next;
            xfer_reg <= xfer_next;
            comp_reg <= comp_next;
        end
    end

    // Pins: serial clock and data shared with slaves listening on the same wires
    assign cfg_mem_select_n_out = sel_reg;
    assign cfg_serial_clock_out = sclk_reg;
    assign serial_cmd_address_out = hsh_reg[31];
    assign cfg_mem_select_oe_n = oe_n_reg;
    assign cfg_serial_clock_oe_n = oe_n_reg;
    assign serial_cmd_address_oe_n = oe_n_reg;

    // System side: toggle crossing, decompressor, two-entry buffer
    logic tg_s1_reg, tg_s2_reg;
    logic st_s1_reg, st_s2_reg, ab_s1_reg, ab_s2_reg, bz_s1_reg, bz_s2_reg;
    ascm_word_type buf_reg [2], buf_next [2];
    logic [1:0] cnt_reg, cnt_next;
    logic wp_reg, wp_next, rp_reg, rp_next;
    logic [7:0] dout_reg, dout_next;
    logic dval_reg, dval_next;
    logic done_reg, done_next, abort_reg, abort_next, busy_reg;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tg_s1_reg <= 1'b0;
            tg_s2_reg <= 1'b0;
            bz_s1_reg <= 1'b0;
            bz_s2_reg <= 1'b0;
            st_s1_reg <= 1'b0;
            st_s2_reg <= 1'b0;
            ab_s1_reg <= 1'b0;
            ab_s2_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            tg_s1_reg <= push_tgl_reg;
            tg_s2_reg <= tg_s1_reg;
            bz_s1_reg <= (st_reg != ASCM_IDLE);
            bz_s2_reg <= bz_s1_reg;
            st_s1_reg <= (st_reg == ASCM_DONE);
            st_s2_reg <= st_s1_reg;
            ab_s1_reg <= (st_reg == ASCM_ABORT);
            ab_s2_reg <= ab_s1_reg;
        end
    end

    // Compressed words: each byte 8'h00 repeats the previous byte as simple expansion
    always_comb
    begin
        logic arrive;
        logic pop;
        arrive = (tg_s2_reg != ack_tgl_reg) && (cnt_reg != 2'h2);
        pop = dval_reg && cfg_byte_ready;
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        ack_tgl_next = ack_tgl_reg;
        dout_next = dout_reg;
        dval_next = dval_reg && !cfg_byte_ready;
        if (arrive)
        begin
            buf_next[wp_reg] = '{data: xfer_reg, comp: comp_reg};
            wp_next = ~wp_reg;
            ack_tgl_next = tg_s2_reg;
        end
        if ((!dval_reg || pop) && cnt_reg != 2'h0)
        begin
            if (buf_reg[rp_reg].comp && buf_reg[rp_reg].data == 8'h00)
                dout_next = dout_reg;
            else
                dout_next = buf_reg[rp_reg].data;
            dval_next = 1'b1;
            rp_next = ~rp_reg;
        end
        cnt_next = cnt_reg + {1'b0, arrive} - {1'b0, ((!dval_reg || pop) && cnt_reg != 2'h0)};
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            cnt_reg <= '0;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
            dout_reg <= '0;
            dval_reg <= 1'b0;
            done_reg <= 1'b0;
            abort_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            ack_tgl_reg <= ack_tgl_next;
            dout_reg <= dout_next;
            dval_reg <= dval_next;
            done_reg <= st_s2_reg;
            abort_reg <= ab_s2_reg;
            busy_reg <= bz_s2_reg && !st_s2_reg && !ab_s2_reg;
        end
    end

    assign cfg_byte = dout_reg;
    assign cfg_byte_valid = dval_reg;
    assign cfg_done = done_reg;
    assign cfg_aborted = abort_reg;
    assign cfg_busy = busy_reg;

    // Checks on the link domain
    property p_select_low_streaming;
        @(posedge link_clk) disable iff (!link_reset_n)
        (st_reg == ASCM_STREAM) |-> !cfg_mem_select_n_out;
    endproperty
    a_select_low_streaming: assert property (p_select_low_streaming) else $error("select high");
    property p_release_done;
        @(posedge link_clk) disable iff (!link_reset_n)
        (st_reg == ASCM_DONE) |=> cfg_mem_select_oe_n && cfg_serial_clock_oe_n;
    endproperty
    a_release_done: assert property (p_release_done) else $error("pins held");
    property p_jtag_abort;
        @(posedge link_clk) disable iff (!link_reset_n)
        (jtag_s2_reg && st_reg == ASCM_STREAM) |=> (st_reg == ASCM_ABORT);
    endproperty
    a_jtag_abort: assert property (p_jtag_abort) else $error("no abort");
    property p_clock_toggles;
        @(posedge link_clk) disable iff (!link_reset_n)
        (st_reg == ASCM_HEADER && !jtag_s2_reg) |=> (sclk_reg != $past(sclk_reg));
    endproperty
    a_clock_toggles: assert property (p_clock_toggles) else $error("clock stuck");
    property p_clock_held_stall;
        @(posedge link_clk) disable iff (!link_reset_n)
        (st_reg == ASCM_STREAM && stall && sclk_reg && !jtag_s2_reg) |=> sclk_reg;
    endproperty
    a_clock_held_stall: assert property (p_clock_held_stall) else $error("stall clock");
    property p_idle_released;
        @(posedge link_clk) disable iff (!link_reset_n)
        (st_reg == ASCM_IDLE) |-> cfg_mem_select_oe_n && cfg_mem_select_n_out;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("idle pins driven");
endmodule

//--- hw/ascm_pkg.sv
// Function
// - Drive memory select low while configuring
// - Shift read command and address out
// - Internal clock runs 20 to 40 MHz
// - Oscillator maximum suits memory clock limit
// - Optional user clock source, 40 MHz max
// - Release all pins after configuration
// - Slaves share data and clock lines
// - Accept compressed and uncompressed bitstreams
// - Test port configuration stops serial loading
package ascm_pkg;
    localparam logic [7:0] ASCM_READ_CMD = 8'h03;
    localparam logic [23:0] ASCM_START_ADDR = 24'h000000;
    localparam int ASCM_HDR_BITS = 32;
    localparam int ASCM_HDR_CNT_W = 6;
    localparam logic [5:0] ASCM_HDR_LAST = 6'h1F;
    localparam int ASCM_LEN_W = 24;
    localparam logic [23:0] ASCM_STREAM_BYTES = 24'h000100;
    localparam int ASCM_OSC_MAX_MHZ = 40;
    localparam int ASCM_OSC_MIN_MHZ = 20;
    localparam int ASCM_USR_MAX_MHZ = 40;
    localparam logic [2:0] ASCM_RLE_MARK_RESET = 3'h0;

    typedef enum logic [2:0]
    {
        ASCM_IDLE = 3'b000,
        ASCM_SELECT = 3'b001,
        ASCM_HEADER = 3'b010,
        ASCM_STREAM = 3'b011,
        ASCM_DONE = 3'b100,
        ASCM_ABORT = 3'b101
    } ascm_state_type;

    typedef struct packed
    {
        logic [7:0] data;
        logic comp;
    } ascm_word_type;
endpackage

//--- dv/ascm_flash_model.sv
`timescale 1ns/1ps
module ascm_flash_model
(
    // Board-level pins
    wire logic sel_n,
    wire logic sclk,
    wire logic cmd,
    // Data back to the loader
    output logic dout
);
    logic [31:0] hdr;
    logic [5:0] hcnt;
    logic [11:0] bidx;
    logic [7:0] cur;

    // Command and address taken on rising clock
    always @(posedge sclk or posedge sel_n)
    begin
        if (sel_n)
        begin
            hcnt <= 6'h00;
        end
        else if (hcnt < 6'h20)
        begin
            hdr <= {hdr[30:0], cmd};
            hcnt <= hcnt + 6'h01;
        end
    end

    // Stream on falling clock; idle line floats high on its pull-up
    always @(negedge sclk or posedge sel_n)
    begin
        if (sel_n || hcnt != 6'h20)
        begin
            dout <= 1'b1;
            if (sel_n)
                bidx <= 12'h000;
        end
        else
        begin
            cur = bidx[10:3] ^ 8'hA5;
            dout <= cur[7 - bidx[2:0]];
            bidx <= bidx + 12'h001;
        end
    end
endmodule

//--- dv/ascm_master_bench.sv
`timescale 1ns/1ps
module ascm_master_bench
    import ascm_pkg::*;
;
    logic clk_sys = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic link_reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic start_cfg = 1'b0;
    logic compressed_in = 1'b0;
    logic jtag_cfg_in = 1'b0;
    logic cfg_byte_ready = 1'b1;
    logic sel_n, sel_oe_n, sclk, sclk_oe_n, cmd, cmd_oe_n, data_w;
    logic [7:0] cfg_byte;
    logic cfg_byte_valid, cfg_busy, cfg_done, cfg_aborted;
    int num_errors = 0;
    int comparisons = 0;
    // Released pins float high through the pull-ups
    wire logic sel_w = sel_oe_n ? 1'b1 : sel_n;
    wire logic sclk_w = sclk_oe_n ? 1'b1 : sclk;
    wire logic cmd_w = cmd_oe_n ? 1'b1 : cmd;

    always #50 clk_sys = ~clk_sys;
    // Link clock offset so its edges drift against the system clock
    initial
    begin
        #13;
        forever #32 link_clk = ~link_clk;
    end

    ascm_master ascm_master_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .start_cfg(start_cfg), .compressed_in(compressed_in), .jtag_cfg_in(jtag_cfg_in),
        .link_clk(link_clk), .link_reset_n(link_reset_n),
        .cfg_mem_select_n_out(sel_n), .cfg_mem_select_oe_n(sel_oe_n),
        .cfg_serial_clock_out(sclk), .cfg_serial_clock_oe_n(sclk_oe_n),
        .serial_cmd_address_out(cmd), .serial_cmd_address_oe_n(cmd_oe_n),
        .cfg_data_in(data_w), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
        .cfg_byte_ready(cfg_byte_ready), .cfg_busy(cfg_busy), .cfg_done(cfg_done),
        .cfg_aborted(cfg_aborted));

    ascm_flash_model flash_i (.sel_n(sel_w), .sclk(sclk_w), .cmd(cmd_w), .dout(data_w));

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    // Both domains reset together; start waits past the link settling edges
    task restart;
        @(posedge clk_sys);
        reset_n <= 1'b0;
        link_reset_n <= 1'b0;
        start_cfg <= 1'b0;
        jtag_cfg_in <= 1'b0;
        cfg_byte_ready <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        link_reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task test_load(input logic comp, input logic stall);
        int k;
        int cyc;
        logic [7:0] raw;
        logic [7:0] exp;
        logic [7:0] prev;
        restart;
        compressed_in <= comp;
        start_cfg <= 1'b1;
        for (cyc = 0; cyc < 100 && sel_w !== 1'b0; cyc++)
            @(posedge clk_sys);
        check(sel_w, 1'b0, "select not driven");
        prev = 8'h00;
        k = 0;
        // A long early stall fills the buffer before draining
        for (cyc = 0; cyc < 20000 && k < 256; cyc++)
        begin
            @(posedge clk_sys);
            if (cfg_byte_valid === 1'b1 && cfg_byte_ready === 1'b1)
            begin
                raw = k[7:0] ^ 8'hA5;
                exp = (comp && raw == 8'h00) ? prev : raw;
                if (k == 0)
                    check(cfg_busy, 1'b1, "not busy");
                check(cfg_byte, exp, "byte");
                prev = exp;
                k++;
            end
            cfg_byte_ready <= !stall || (cyc > 300 && cyc[1]);
        end
        check(k, 256, "byte count");
        check(flash_i.hdr, {ASCM_READ_CMD, ASCM_START_ADDR}, "read header");
        for (cyc = 0; cyc < 200 && cfg_done !== 1'b1; cyc++)
            @(posedge clk_sys);
        #1;
        check({sel_oe_n, sclk_oe_n, cmd_oe_n, cfg_done, cfg_busy}, 5'h1E, "pins held");
        $display("load test finished");
    endtask

    task test_abort;
        int cyc;
        restart;
        start_cfg <= 1'b1;
        repeat (500) @(posedge clk_sys);
        jtag_cfg_in <= 1'b1;
        for (cyc = 0; cyc < 100 && cfg_aborted !== 1'b1; cyc++)
            @(posedge clk_sys);
        #1;
        check({cfg_aborted, sel_oe_n, sclk_oe_n, cmd_oe_n}, 4'hF, "abort");
        $display("abort test finished");
    endtask

    task test_refuse;
        restart;
        jtag_cfg_in <= 1'b1;
        start_cfg <= 1'b1;
        repeat (100) @(posedge clk_sys);
        check({sel_oe_n, cfg_byte_valid}, 2'h2, "start taken");
        $display("refuse test finished");
    endtask

    task wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well above the four tests
    initial
    begin
        #3000000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up;
    end

    initial
    begin
        test_load(1'b0, 1'b1);
        test_load(1'b1, 1'b0);
        test_abort;
        test_refuse;
        wrap_up;
    end
endmodule
